// File: iosad_pkg.sv
// constants and types shared by the i/o space access decode block
package iosad_pkg;

   // ---------------------------------------------------------------
   // widths and address map
   // ---------------------------------------------------------------
   localparam int unsigned ADDR_W         = 8;
   localparam int unsigned DATA_W         = 8;
   localparam int unsigned NUM_LOW        = 32;      // bit-accessible registers
   localparam int unsigned NUM_T2         = 5;       // timer 2 registers
   localparam logic [7:0]  IO_BIT_LAST    = 8'h1f;   // last bit-accessible i/o address
   localparam logic [7:0]  IO_LAST        = 8'h3f;   // last address of the i/o view
   localparam logic [7:0]  DATA_IO_OFFSET = 8'h20;   // data view = i/o address + this
   localparam logic [7:0]  EXT_FIRST      = 8'h60;   // first extended address
   localparam logic [7:0]  EXT_LAST       = 8'hff;   // last extended address

   // ---------------------------------------------------------------
   // timer 2 registers, data-space offsets
   // ---------------------------------------------------------------
   localparam logic [7:0]  T2_CONTROL_A_OFS = 8'hb0;
   localparam logic [7:0]  T2_CONTROL_B_OFS = 8'hb1;
   localparam logic [7:0]  T2_COUNT_OFS     = 8'hb2;
   localparam logic [7:0]  T2_COMPARE_A_OFS = 8'hb3;
   localparam logic [7:0]  T2_COMPARE_B_OFS = 8'hb4;
   localparam logic [2:0]  T2_CONTROL_A_IDX = 3'h0;
   localparam logic [2:0]  T2_CONTROL_B_IDX = 3'h1;
   localparam logic [7:0]  T2_RESET         = 8'h00;

   // ---------------------------------------------------------------
   // field layouts
   // ---------------------------------------------------------------
   localparam logic [7:0]  T2_CONTROL_A_MASK = 8'hf3;  // bits 3:2 reserved
   localparam logic [7:0]  T2_CONTROL_B_MASK = 8'h0f;  // 7:6 strobes, 5:4 reserved
   localparam int unsigned T2_FORCE_A_BIT    = 7;
   localparam int unsigned T2_FORCE_B_BIT    = 6;

   // ---------------------------------------------------------------
   // low bank layout
   // ---------------------------------------------------------------
   localparam logic [4:0]  FLAG_IO_ADDR = 5'h16;     // write-one-to-clear flags
   localparam logic [7:0]  LOW_RESET    = 8'h00;

   // core operations; load and store variants of each addressing form have their own code
   typedef enum logic [2:0] {
      OP_IO_READ,
      OP_IO_WRITE,
      OP_DATA_LOAD,
      OP_DATA_STORE,
      OP_SET_IO_BIT,
      OP_CLEAR_IO_BIT,
      OP_SKIP_IF_IO_BIT_SET,
      OP_SKIP_IF_IO_BIT_CLEAR
   } iosad_op_e;

endpackage

// File: iosad_dec_if.sv
// decoded address information passed from the decoder to the register bank
`timescale 1ns/1ps
interface iosad_dec_if;
   import iosad_pkg::*;

   iosad_op_e   op;
   logic [7:0]  addr;
   logic        legal;      // operation may touch the address
   logic        low_hit;    // bit-accessible bank
   logic [4:0]  low_idx;
   logic        t2_hit;     // timer 2 register
   logic [2:0]  t2_idx;
   logic        is_write;
   logic        is_bit;

   modport dec (input op, addr, output legal, low_hit, low_idx, t2_hit, t2_idx,
                is_write, is_bit);
   modport bank (output op, addr, input legal, low_hit, low_idx, t2_hit, t2_idx,
                 is_write, is_bit);
endinterface

// File: iosad_decode.sv
// address decoder: maps i/o and data-space views onto the register bank
`timescale 1ns/1ps
module iosad_decode
   import iosad_pkg::*;
(
   iosad_dec_if.dec d
);

   logic [7:0] data_addr;
   logic       io_view;

   // --------------------------------------------------------------
   // view translation
   // --------------------------------------------------------------
   always_comb begin
      io_view    = (d.op == OP_IO_READ) || (d.op == OP_IO_WRITE);
      d.is_bit   = (d.op == OP_SET_IO_BIT) || (d.op == OP_CLEAR_IO_BIT) ||
                   (d.op == OP_SKIP_IF_IO_BIT_SET) || (d.op == OP_SKIP_IF_IO_BIT_CLEAR);
      d.is_write = (d.op == OP_IO_WRITE) || (d.op == OP_DATA_STORE) ||
                   (d.op == OP_SET_IO_BIT) || (d.op == OP_CLEAR_IO_BIT);
      if (io_view || d.is_bit) begin
         data_addr = d.addr + DATA_IO_OFFSET;
      end else begin
         data_addr = d.addr;
      end
      if (d.is_bit) begin
         d.legal = (d.addr <= IO_BIT_LAST);
      end else if (io_view) begin
         d.legal = (d.addr <= IO_LAST);
      end else begin
         d.legal = (d.addr >= DATA_IO_OFFSET) && (d.addr <= EXT_LAST);
      end
      d.low_hit = (data_addr >= DATA_IO_OFFSET) &&
                  (data_addr <= (IO_BIT_LAST + DATA_IO_OFFSET));
      d.low_idx = 5'(data_addr - DATA_IO_OFFSET);
      d.t2_hit  = (data_addr >= T2_CONTROL_A_OFS) && (data_addr <= T2_COMPARE_B_OFS);
      d.t2_idx  = 3'(data_addr - T2_CONTROL_A_OFS);
   end

endmodule // iosad_decode

// File: iosad_io_space.sv
// i/o register space: bit operations, w1c flags, i/o and data views, timer 2 regs
`timescale 1ns/1ps
module iosad_io_space
   import iosad_pkg::*;
(
   input  wire logic                      clk_sys,
   input  wire logic                      sys_rst,
   input  wire logic                      req_valid,
   input  wire iosad_op_e                 req_op,
   input  wire logic [ADDR_W-1:0]         req_addr,
   input  wire logic [2:0]                req_bit,
   input  wire logic [DATA_W-1:0]         req_wdata,
   input  wire logic [DATA_W-1:0]         flag_set,
   output logic                           rsp_valid,
   output logic [DATA_W-1:0]              rsp_rdata,
   output logic                           rsp_skip,
   output logic                           rsp_err,
   output logic [NUM_LOW*DATA_W-1:0]      low_bank_out,
   output logic [DATA_W-1:0]              timer2_control_a,
   output logic [DATA_W-1:0]              timer2_control_b,
   output logic [DATA_W-1:0]              timer2_count_value,
   output logic [DATA_W-1:0]              timer2_compare_a,
   output logic [DATA_W-1:0]              timer2_compare_b,
   output logic                           timer2_force_a,
   output logic                           timer2_force_b
);

   // --------------------------------------------------------------
   // state
   // --------------------------------------------------------------
   // bit-accessible bank and timer 2 storage with their next values
   logic [DATA_W-1:0] low_bank [NUM_LOW];
   logic [DATA_W-1:0] next_low_bank [NUM_LOW];
   logic [DATA_W-1:0] t2_bank [NUM_T2];
   logic [DATA_W-1:0] next_t2_bank [NUM_T2];
   // response and strobe next values
   logic              next_rsp_valid;
   logic [DATA_W-1:0] next_rsp_rdata;
   logic              next_rsp_skip;
   logic              next_rsp_err;
   logic              next_force_a;
   logic              next_force_b;
   // shared decode of the current request
   logic [DATA_W-1:0] bit_mask;
   logic [DATA_W-1:0] cur;
   logic              do_it;

   iosad_dec_if dec_bus ();

   // address decode of the current request
   assign dec_bus.op   = req_op;
   assign dec_bus.addr = req_addr;

   iosad_decode u_decode (
      .d (dec_bus.dec)
   );

   // --------------------------------------------------------------
   // request qualification
   // --------------------------------------------------------------
   // selected bit, permission and the value at the decoded address
   always_comb begin
      bit_mask = 8'h01 << req_bit;
      do_it    = req_valid && dec_bus.legal;
      // cur feeds reads, skip tests and single-bit read-modify-write
      if (dec_bus.low_hit) begin
         cur = low_bank[dec_bus.low_idx];
      end else if (dec_bus.t2_hit) begin
         cur = t2_bank[dec_bus.t2_idx];                        // reserved bits stored as 0
      end else begin
         cur = '0;
      end
   end

   // --------------------------------------------------------------
   // response
   // --------------------------------------------------------------
   // refused requests still answer, with the error flag and no data
   always_comb begin
      next_rsp_valid = req_valid;
      next_rsp_err   = req_valid && !dec_bus.legal;
      next_rsp_rdata = '0;
      next_rsp_skip  = 1'b0;
      if (do_it && !dec_bus.is_write) begin
         next_rsp_rdata = cur;
      end
      // single-bit tests give the skip decision
      if (do_it && (req_op == OP_SKIP_IF_IO_BIT_SET)) begin
         next_rsp_skip = |(cur & bit_mask);
      end else if (do_it && (req_op == OP_SKIP_IF_IO_BIT_CLEAR)) begin
         next_rsp_skip = ~|(cur & bit_mask);
      end
   end

   // response registers, loaded on the taking edge
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         rsp_valid <= 1'b0;
         rsp_rdata <= '0;
         rsp_skip  <= 1'b0;
         rsp_err   <= 1'b0;
      end else begin
         rsp_valid <= next_rsp_valid;
         rsp_rdata <= next_rsp_rdata;
         rsp_skip  <= next_rsp_skip;
         rsp_err   <= next_rsp_err;
      end
   end

   // --------------------------------------------------------------
   // bit-accessible bank
   // --------------------------------------------------------------
   // plain storage, except the flag register which clears on ones
   always_comb begin
      next_low_bank = low_bank;
      if (do_it && dec_bus.is_write && dec_bus.low_hit) begin
         if (req_op == OP_SET_IO_BIT) begin
            // a set on the flag register writes a one, clearing that flag
            if (dec_bus.low_idx == FLAG_IO_ADDR) begin
               next_low_bank[dec_bus.low_idx] = cur & ~bit_mask;
            end else begin
               next_low_bank[dec_bus.low_idx] = cur | bit_mask;
            end
         end else if (req_op == OP_CLEAR_IO_BIT) begin
            // a clear on the flag register writes a zero, so flags stay
            if (dec_bus.low_idx != FLAG_IO_ADDR) begin
               next_low_bank[dec_bus.low_idx] = cur & ~bit_mask;
            end
         end else if (dec_bus.low_idx == FLAG_IO_ADDR) begin
            next_low_bank[dec_bus.low_idx] = cur & ~req_wdata;
         end else begin
            // byte writes from the i/o and data views
            next_low_bank[dec_bus.low_idx] = req_wdata;
         end
      end
      // hardware flag events win over a clear in the same cycle
      next_low_bank[FLAG_IO_ADDR] = next_low_bank[FLAG_IO_ADDR] | flag_set;
   end

   // bank registers; unmapped addresses have no storage at all
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_LOW; i++) begin
            low_bank[i] <= LOW_RESET;
         end
      end else begin
         low_bank <= next_low_bank;
      end
   end

   // --------------------------------------------------------------
   // timer 2 registers
   // --------------------------------------------------------------
   // control registers keep only their defined bits; force bits pulse
   always_comb begin
      next_t2_bank = t2_bank;
      next_force_a = 1'b0;
      next_force_b = 1'b0;
      // count value is only stored; counting lives outside this block
      if (do_it && dec_bus.is_write && dec_bus.t2_hit) begin
         case (dec_bus.t2_idx)
            T2_CONTROL_A_IDX: begin
               next_t2_bank[dec_bus.t2_idx] = req_wdata & T2_CONTROL_A_MASK;
            end
            T2_CONTROL_B_IDX: begin
               next_t2_bank[dec_bus.t2_idx] = req_wdata & T2_CONTROL_B_MASK;
               next_force_a = req_wdata[T2_FORCE_A_BIT];       // strobe, reads zero
               next_force_b = req_wdata[T2_FORCE_B_BIT];
            end
            default: begin
               next_t2_bank[dec_bus.t2_idx] = req_wdata;
            end
         endcase
      end
   end

   // timer 2 storage and the one-cycle force strobes
   always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
         for (int i = 0; i < NUM_T2; i++) begin
            t2_bank[i] <= T2_RESET;
         end
         timer2_force_a <= 1'b0;
         timer2_force_b <= 1'b0;
      end else begin
         t2_bank        <= next_t2_bank;
         timer2_force_a <= next_force_a;
         timer2_force_b <= next_force_b;
      end
   end

   // --------------------------------------------------------------
   // register outputs
   // --------------------------------------------------------------
   // flat copy of the bank for the port and timer logic
   for (genvar g = 0; g < NUM_LOW; g++) begin : g_low_out
      assign low_bank_out[g*DATA_W +: DATA_W] = low_bank[g];
   end

   // timer 2 register values toward the counting logic
   assign timer2_control_a   = t2_bank[0];
   assign timer2_control_b   = t2_bank[1];
   assign timer2_count_value = t2_bank[2];
   assign timer2_compare_a   = t2_bank[3];
   assign timer2_compare_b   = t2_bank[4];

endmodule // iosad_io_space

// File: iosad_io_space_props.sv
// concurrent checks on the ports of the i/o space access decode block
`timescale 1ns/1ps
module iosad_io_space_props
   import iosad_pkg::*;
(
   input wire logic                      clk_sys,
   input wire logic                      sys_rst,
   input wire logic                      req_valid,
   input wire iosad_op_e                 req_op,
   input wire logic [ADDR_W-1:0]         req_addr,
   input wire logic [2:0]                req_bit,
   input wire logic [DATA_W-1:0]         req_wdata,
   input wire logic [DATA_W-1:0]         flag_set,
   input wire logic                      rsp_valid,
   input wire logic [DATA_W-1:0]         rsp_rdata,
   input wire logic                      rsp_skip,
   input wire logic                      rsp_err,
   input wire logic [NUM_LOW*DATA_W-1:0] low_bank_out,
   input wire logic [DATA_W-1:0]         timer2_control_b,
   input wire logic                      timer2_force_a
);
   // ---------------------------------------------------------------
   // helper decode
   // ---------------------------------------------------------------
   logic [7:0] bit_idx;
   logic       sel_bit;
   logic [7:0] low_byte;
   logic [7:0] flag_byte;
   logic       quiet;
   logic       plain;
   logic       wr_force;
   // request fields and the register bytes they point at
   assign bit_idx   = {req_addr[4:0], req_bit};
   assign sel_bit   = low_bank_out[bit_idx];
   assign low_byte  = low_bank_out[req_addr[4:0]*8 +: 8];
   assign flag_byte = low_bank_out[FLAG_IO_ADDR*8 +: 8];
   assign quiet     = req_valid && flag_set == 8'h00;
   assign plain     = req_addr <= IO_BIT_LAST && req_addr[4:0] != FLAG_IO_ADDR;
   assign wr_force  = req_wdata[T2_FORCE_A_BIT];

   default clocking @(posedge clk_sys); endclocking
   default disable iff (sys_rst);

   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   rsp_pulse_a: assert property (req_valid |=> rsp_valid) else $error("no response after request");
   set_bit_a: assert property (quiet && req_op == OP_SET_IO_BIT && plain |=>
      low_bank_out == ($past(low_bank_out) | (256'h1 << $past(bit_idx)))) else $error("bit set wrong");
   clr_bit_a: assert property (quiet && req_op == OP_CLEAR_IO_BIT && plain |=>
      low_bank_out == ($past(low_bank_out) & ~(256'h1 << $past(bit_idx)))) else $error("bit clear wrong");
   skip_test_a: assert property (req_valid && req_op == OP_SKIP_IF_IO_BIT_CLEAR
      && req_addr <= IO_BIT_LAST |=> rsp_skip != $past(sel_bit)) else $error("skip decision wrong");
   w1c_flag_a: assert property (quiet && req_op == OP_IO_WRITE && req_addr == 8'h16 |=>
      flag_byte == ($past(flag_byte) & ~$past(req_wdata))) else $error("flag clear wrong");
   bit_range_a: assert property (quiet && req_op inside {OP_SET_IO_BIT, OP_CLEAR_IO_BIT}
      && req_addr > IO_BIT_LAST |=> rsp_err && $stable(low_bank_out)) else $error("bit op not refused");
   io_range_a: assert property (req_valid && req_op inside {OP_IO_READ, OP_IO_WRITE}
      && req_addr > IO_LAST |=> rsp_err) else $error("io op past range accepted");
   data_view_a: assert property (req_valid && req_op == OP_DATA_LOAD && req_addr inside
      {[8'h20:8'h3f]} |=> rsp_rdata == $past(low_byte) && !rsp_err) else $error("data view wrong");
   ext_store_a: assert property (req_valid && req_op == OP_DATA_STORE && req_addr ==
      T2_CONTROL_B_OFS |=> timer2_force_a == $past(wr_force)) else $error("force pulse wrong");
   resv_io_a: assert property (quiet && req_op inside {OP_IO_READ, OP_IO_WRITE} && req_addr
      inside {[8'h20:8'h3f]} |=> rsp_rdata == 8'h00 && !rsp_err && $stable(low_bank_out))
      else $error("reserved access wrong");

   // main scenarios reached
   cov_set_c: cover property (req_valid && req_op == OP_SET_IO_BIT && plain);
   cov_skip_c: cover property (req_valid && req_op == OP_SKIP_IF_IO_BIT_CLEAR);
   cov_force_c: cover property (timer2_force_a && timer2_control_b != 8'h00);
endmodule // iosad_io_space_props

bind iosad_io_space iosad_io_space_props u_props (.clk_sys(clk_sys), .sys_rst(sys_rst),
   .req_valid(req_valid), .req_op(req_op), .req_addr(req_addr), .req_bit(req_bit),
   .req_wdata(req_wdata), .flag_set(flag_set), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata),
   .rsp_skip(rsp_skip), .rsp_err(rsp_err), .low_bank_out(low_bank_out),
   .timer2_control_b(timer2_control_b), .timer2_force_a(timer2_force_a));

// File: iosad_core_model.sv
// behavioural processor core issuing i/o, bit and load/store requests
`timescale 1ns/1ps
module iosad_core_model
   import iosad_pkg::*;
(
   input  wire logic              clk_sys,
   output logic                   req_valid,
   output iosad_op_e              req_op,
   output logic [ADDR_W-1:0]      req_addr,
   output logic [2:0]             req_bit,
   output logic [DATA_W-1:0]      req_wdata
);
   // idle request lines at time zero
   initial begin
      req_valid = 1'b0;
      req_op    = OP_IO_READ;
      req_addr  = 8'h00;
      req_bit   = 3'h0;
      req_wdata = 8'h00;
   end

   // one request held through its taking edge; data passed as given, normal traffic
   // keeps reserved bits zero and avoids reserved addresses
   task automatic issue(input iosad_op_e op, input logic [7:0] addr, input logic [2:0] bsel,
                        input logic [7:0] wdata);
      @(posedge clk_sys);
      req_valid <= 1'b1;
      req_op    <= op;
      req_addr  <= addr;
      req_bit   <= bsel;
      req_wdata <= wdata;
      @(posedge clk_sys);
      req_valid <= 1'b0;
      req_addr  <= ~addr;   // released address and data lines no longer show the old value
      req_wdata <= ~wdata;
      #1;
   endtask
endmodule // iosad_core_model

// File: tb_io_space_access_decode.sv
// self-checking bench for the i/o space access decode block
`timescale 1ns/1ps
module tb_io_space_access_decode;
   import iosad_pkg::*;
   logic              clk_sys = 1'b0;
   logic              sys_rst = 1'b1;
   logic [7:0]        flag_set = 8'h00;
   logic              req_valid;
   iosad_op_e         req_op;
   logic [7:0]        req_addr;
   logic [2:0]        req_bit;
   logic [7:0]        req_wdata;
   logic              rsp_valid;
   logic [7:0]        rsp_rdata;
   logic              rsp_skip;
   logic              rsp_err;
   logic [255:0]      low_bank_out;
   logic [7:0]        t2_ca, t2_cb, t2_cnt, t2_oa, t2_ob;
   logic              force_a, force_b;
   int                fail_count = 0;
   int                check_count = 0;
   int                cycles = 0;

   always #4 clk_sys = ~clk_sys;

   iosad_core_model core (.clk_sys(clk_sys), .req_valid(req_valid), .req_op(req_op),
      .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata));
   iosad_io_space uut (.clk_sys(clk_sys), .sys_rst(sys_rst), .req_valid(req_valid),
      .req_op(req_op), .req_addr(req_addr), .req_bit(req_bit), .req_wdata(req_wdata),
      .flag_set(flag_set), .rsp_valid(rsp_valid), .rsp_rdata(rsp_rdata), .rsp_skip(rsp_skip),
      .rsp_err(rsp_err), .low_bank_out(low_bank_out), .timer2_control_a(t2_ca),
      .timer2_control_b(t2_cb), .timer2_count_value(t2_cnt), .timer2_compare_a(t2_oa),
      .timer2_compare_b(t2_ob), .timer2_force_a(force_a), .timer2_force_b(force_b));

   // byte compare, counted
   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      check_count++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   // one request, then its response strobe
   task automatic op(input iosad_op_e o, input logic [7:0] a, input logic [2:0] b,
                     input logic [7:0] d);
      core.issue(o, a, b, d);
      chk("response strobe", 8'h01, {7'h0, rsp_valid});
   endtask

   function automatic logic [7:0] low(input int i);
      return low_bank_out[i*8 +: 8];
   endfunction

   task automatic t_bits();
      op(OP_IO_WRITE, 8'h05, 3'h0, 8'h81);
      op(OP_SET_IO_BIT, 8'h05, 3'h2, 8'h00);
      chk("set bit", 8'h85, low(5));
      op(OP_SKIP_IF_IO_BIT_SET, 8'h05, 3'h2, 8'h00);
      chk("skip on set", 8'h01, {7'h0, rsp_skip});
      op(OP_SKIP_IF_IO_BIT_CLEAR, 8'h05, 3'h2, 8'h00);
      chk("skip on clear", 8'h00, {7'h0, rsp_skip});
      op(OP_CLEAR_IO_BIT, 8'h05, 3'h7, 8'h00);
      chk("clear bit", 8'h05, low(5));
      op(OP_SET_IO_BIT, 8'h1f, 3'h0, 8'h00);
      chk("last bit register", 8'h01, low(31));
      op(OP_SET_IO_BIT, 8'h20, 3'h0, 8'h00);
      chk("bit op past range", 8'h01, {7'h0, rsp_err});
      $display("test bits done");
   endtask

   task automatic t_flag();
      @(posedge clk_sys) flag_set <= 8'hff;
      @(posedge clk_sys) flag_set <= 8'h00;
      op(OP_SET_IO_BIT, 8'h16, 3'h1, 8'h00);
      chk("flag after set op", 8'hfd, low(22));
      op(OP_CLEAR_IO_BIT, 8'h16, 3'h3, 8'h00);
      chk("flag after clear op", 8'hfd, low(22));
      op(OP_DATA_STORE, 8'h36, 3'h0, 8'h0c);
      chk("flag after store", 8'hf1, low(22));
      // hardware event on bit 0 in the very cycle a write of one clears it
      fork
         core.issue(OP_IO_WRITE, 8'h16, 3'h0, 8'h01);
         begin
            @(posedge clk_sys) flag_set <= 8'h01;
            @(posedge clk_sys) flag_set <= 8'h00;
         end
      join
      chk("flag set beats clear", 8'hf1, low(22));
      op(OP_IO_WRITE, 8'h16, 3'h0, 8'h10);
      chk("flag after io write", 8'he1, low(22));
      $display("test flag done");
   endtask

   task automatic t_views();
      op(OP_IO_WRITE, 8'h07, 3'h0, 8'ha5);
      op(OP_DATA_LOAD, 8'h27, 3'h0, 8'h00);
      chk("load via data view", 8'ha5, rsp_rdata);
      op(OP_IO_READ, 8'h07, 3'h0, 8'h00);
      chk("io read back", 8'ha5, rsp_rdata);
      op(OP_IO_WRITE, 8'hb0, 3'h0, 8'h33);
      chk("io op on extended", 8'h01, {7'h0, rsp_err});
      for (int i = 0; i < 5; i++) begin
         op(OP_DATA_STORE, T2_CONTROL_A_OFS + 8'(i), 3'h0, 8'h5a);
         op(OP_DATA_LOAD, T2_CONTROL_A_OFS + 8'(i), 3'h0, 8'h00);
         chk("timer 2 readback", 8'h5a & (i == 0 ? T2_CONTROL_A_MASK : i == 1 ?
             T2_CONTROL_B_MASK : 8'hff), rsp_rdata);
      end
      chk("control a output", 8'h5a & T2_CONTROL_A_MASK, t2_ca);
      chk("count value output", 8'h5a, t2_cnt);
      chk("compare a output", 8'h5a, t2_oa);
      chk("compare b output", 8'h5a, t2_ob);
      op(OP_DATA_STORE, T2_CONTROL_B_OFS, 3'h0, 8'hc5);
      chk("force pulses", 8'h03, {6'h0, force_a, force_b});
      chk("control b output", 8'hc5 & T2_CONTROL_B_MASK, t2_cb);
      @(posedge clk_sys);
      #1;
      chk("force pulses end", 8'h00, {6'h0, force_a, force_b});
      $display("test views done");
   endtask

   task automatic t_resv();
      op(OP_IO_WRITE, 8'h30, 3'h0, 8'hff);
      op(OP_IO_READ, 8'h30, 3'h0, 8'h00);
      chk("reserved io read", 8'h00, rsp_rdata);
      op(OP_DATA_STORE, 8'ha0, 3'h0, 8'hff);
      op(OP_DATA_LOAD, 8'ha0, 3'h0, 8'h00);
      chk("reserved load data", 8'h00, rsp_rdata);
      chk("reserved load error", 8'h00, {7'h0, rsp_err});
      op(OP_DATA_LOAD, 8'h10, 3'h0, 8'h00);
      chk("load below io space", 8'h01, {7'h0, rsp_err});
      $display("test reserved done");
   endtask

   task automatic t_reset();
      @(posedge clk_sys) sys_rst <= 1'b1;
      repeat (2) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("register after reset", LOW_RESET, low(5));
      chk("flag after reset", LOW_RESET, low(22));
      chk("timer 2 after reset", T2_RESET, t2_ob);
      $display("test reset done");
   endtask

   task automatic finish_test();
      $display("checks %0d, mismatches %0d", check_count, fail_count);
      if (fail_count == 0 && check_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   // hang guard
   always @(posedge clk_sys) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         finish_test();
      end
   end

   initial begin
      repeat (12) @(posedge clk_sys);
      sys_rst <= 1'b0;
      @(posedge clk_sys);
      #1;
      chk("control a reset", T2_RESET, t2_ca);
      chk("flag reset", LOW_RESET, low(22));
      t_bits();
      t_flag();
      t_views();
      t_resv();
      t_reset();
      finish_test();
   end
endmodule // tb_io_space_access_decode
